//--- scr_regs.vh
/*
 Register map, field positions, reset values and timing counts of the
 serializer configuration register bank. Assumes a 250 MHz system clock.
*/
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

`define SCR_ADDR_CMD 7'h00
`define SCR_ADDR_PTR_R 7'h02
`define SCR_ADDR_DAT_R 7'h03
`define SCR_ADDR_PTR_G 7'h04
`define SCR_ADDR_DAT_G 7'h05
`define SCR_ADDR_PTR_B 7'h06
`define SCR_ADDR_DAT_B 7'h07
`define SCR_ADDR_DITH1 7'h08
`define SCR_ADDR_DITH2 7'h09
`define SCR_ADDR_CFG3 7'h0B
`define SCR_ADDR_UNLOCK 7'h16

`define SCR_CMD_LUT_EN 0
`define SCR_CMD_SRA 4
`define SCR_DITH_BYPASS 0
`define SCR_DITH_DE_FLIP 1
`define SCR_DITH_VS_FLIP 2
`define SCR_DITH_TRANSPOSE 4
`define SCR_DITH_TEMPORAL 5
`define SCR_DITH_AMPL 6
`define SCR_CFG3_MODE24 0
`define SCR_CFG3_SOFT_RST 1
`define SCR_CFG3_DRIVE_LO 4
`define SCR_CFG3_DRIVE_HI 5

`define SCR_RST_CMD 8'h00
`define SCR_RST_DITH1 8'h65
`define SCR_RST_DITH2 8'h67
`define SCR_RST_CFG3 8'h00
`define SCR_RST_UNLOCK 8'h00
`define SCR_UNLOCK_KEY 8'hFF

`define SCR_MULT_18 4'h6
`define SCR_MULT_24 4'h8
`define SCR_PAGE_MAX 9'h100

`define SCR_CLK_MHZ 250
`define SCR_STALL_NS 1000
`define SCR_STALL_CYCLES ((`SCR_STALL_NS * `SCR_CLK_MHZ + 999) / 1000)

`endif

//--- scr_config_regs.v
/*
 Configuration register bank of a display serializer: serial port slave,
 three colour lookup tables, mode, dither and drive settings, sleep logic.
 Assumes all serial pins and the pixel clock are asynchronous to CLK and
 are sampled at 250 MHz; the pixel words arrive on CLK.
*/
// How it works
// - Command bit 0 turns the colour lookup table on; register resets to zero.
// - Command bit 4 unlocks the dither and third configuration registers.
// - Each colour pointer resets to zero and steps after each data access.
// - First dither register bit 0 bypasses dither; default 0x65.
// - Bit 1 flips data-enable polarity for the dither block only.
// - Bit 2 flips vertical-sync polarity for the dither block only.
// - Bit 4 selects a transposed dither pattern.
// - Bit 5 turns temporal dithering on.
// - Bit 6 picks three-bit amplitude, else four-bit.
// - Third configuration bit 0 picks 24-bit transport, else 18-bit.
// - Third configuration bit 1 holds the serializer in reset.
// - Third configuration bits 5:4 pick the output drive level.
// - Serial port reaches registers other than unlock only while unlock holds 0xFF.
// - Reserved bits are written as zero and read as zero here.
// - Dither and third configuration registers are write-only.
// - Link clock multiplier is 6 in 18-bit mode, 8 in 24-bit mode.
// - Power-down pin low sleeps and resets registers, table kept.
// - Stalled pixel clock sleeps, keeping registers and table.
// - Write frame: zero, seven address bits, eight data bits.
// - Read frame: one, seven address bits, then eight bits driven out.
// - Page write streams up to 256 bytes while select stays low.
`timescale 1ns/100ps
`include "scr_regs.vh"

module scr_config_regs #(
    parameter STALL_CYCLES = `SCR_STALL_CYCLES
) (
    input wire CLK,
    input wire RESET_N,
    input wire CE,
    input wire SERIAL_SELECT_N,
    input wire SERIAL_CLK,
    input wire SERIAL_DATA_IN,
    input wire POWER_DOWN_N,
    input wire PIXEL_CLK,
    input wire [7:0] RED_IN,
    input wire [7:0] GREEN_IN,
    input wire [7:0] BLUE_IN,
    output reg [7:0] RED_OUT,
    output reg [7:0] GREEN_OUT,
    output reg [7:0] BLUE_OUT,
    output reg SERIAL_DATA_OUT,
    output reg SERIAL_DATA_OE,
    output wire TABLE_ENABLE,
    output wire DITHER_BYPASS,
    output wire DITHER_ENABLE_POLARITY_FLIP,
    output wire DITHER_VSYNC_POLARITY_FLIP,
    output wire PATTERN_TRANSPOSE_SELECT,
    output wire TEMPORAL_DITHER_ON,
    output wire DITHER_AMPLITUDE_SELECT,
    output wire [7:0] DITHER_PARAMETER,
    output wire MODE_24,
    output wire [1:0] DRIVE_LEVEL,
    output reg [3:0] LINK_MULT,
    output reg SERIALIZER_RESET,
    output reg SLEEP,
    output reg PORT_ENABLE
);

    localparam [4:0] PIN_IDLE = 5'h01;
    localparam SEL = 0;
    localparam SCK = 1;
    localparam DIN = 2;
    localparam PDN = 3;
    localparam PCK = 4;

    reg [4:0] s1_r;
    reg [4:0] s2_r;
    reg [4:0] s3_r;
    reg [4:0] flt_r;
    wire [4:0] flt_nxt;

    reg [7:0] cmd_r;
    reg [7:0] dith1_r;
    reg [7:0] dith2_r;
    reg [7:0] cfg3_r;
    reg [7:0] unlock_r;
    reg [7:0] ptr_red_r;
    reg [7:0] ptr_green_r;
    reg [7:0] ptr_blue_r;
    reg [7:0] ram_red_r [0:255];
    reg [7:0] ram_green_r [0:255];
    reg [7:0] ram_blue_r [0:255];

    reg [2:0] bit_cnt_r;
    reg hdr_done_r;
    reg is_read_r;
    reg [6:0] addr_r;
    reg [7:0] shift_r;
    reg [8:0] byte_cnt_r;
    reg [7:0] out_sh_r;
    reg [11:0] stall_cnt_r;
    reg stall_r;

    reg [7:0] rd_val;
    wire [7:0] sh_nxt;
    wire pd_low;
    wire sck_rise;
    wire sck_fall;
    wire pck_edge;
    wire frame_act;
    wire byte_end;
    wire wr_fire;
    wire rd_fire;
    wire [6:0] rd_addr;
    wire acc_wr;
    wire acc_rd;
    wire wr_ok;
    wire rd_ok;

    // Address is a table data register
    function is_data;
        input [6:0] a;
        begin
            is_data = (a == `SCR_ADDR_DAT_R) || (a == `SCR_ADDR_DAT_G) ||
                (a == `SCR_ADDR_DAT_B);
        end
    endfunction

    // Access gate: unlock key, then special unlock for protected set
    function acc_ok;
        input [6:0] a;
        input [7:0] unl;
        input special_access_unlock;
        begin
            if (a == `SCR_ADDR_UNLOCK)
                acc_ok = 1'b1;
            else if (unl != `SCR_UNLOCK_KEY)
                acc_ok = 1'b0;
            else if (a == `SCR_ADDR_DITH1 || a == `SCR_ADDR_DITH2 ||
                a == `SCR_ADDR_CFG3)
                acc_ok = special_access_unlock;
            else
                acc_ok = 1'b1;
        end
    endfunction

    // One channel's data register was accessed through the port
    function ptr_step;
        input [6:0] dat;
        input wr_hit;
        input [6:0] wa;
        input rd_hit;
        input [6:0] ra;
        begin
            ptr_step = (wr_hit && wa == dat) || (rd_hit && ra == dat);
        end
    endfunction

    // Second and third stage agree before a pin change counts
    assign flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
            flt_r <= PIN_IDLE;
        end else if (CE) begin
            s1_r <= {PIXEL_CLK, POWER_DOWN_N, SERIAL_DATA_IN, SERIAL_CLK,
                SERIAL_SELECT_N};
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    assign pd_low = ~flt_r[PDN];
    assign sck_rise = flt_nxt[SCK] & ~flt_r[SCK];
    assign sck_fall = ~flt_nxt[SCK] & flt_r[SCK];
    assign pck_edge = flt_nxt[PCK] ^ flt_r[PCK];
    assign frame_act = ~flt_r[SEL] & ~pd_low;
    assign sh_nxt = {shift_r[6:0], flt_nxt[DIN]};
    assign byte_end = frame_act & sck_rise & (bit_cnt_r == 3'h7);
    assign rd_addr = sh_nxt[6:0];
    // Header then data bytes; page write capped at 256 bytes
    assign wr_fire = byte_end & hdr_done_r & ~is_read_r &
        (byte_cnt_r < `SCR_PAGE_MAX);
    assign rd_fire = byte_end & ~hdr_done_r & sh_nxt[7];
    assign acc_wr = acc_ok(addr_r, unlock_r, cmd_r[`SCR_CMD_SRA]);
    assign acc_rd = acc_ok(rd_addr, unlock_r, cmd_r[`SCR_CMD_SRA]);
    // Accesses that pass the lock checks
    assign wr_ok = wr_fire & acc_wr;
    assign rd_ok = rd_fire & acc_rd;

    // Read data: write-only and reserved locations return zero
    always @* begin
        case (rd_addr)
            `SCR_ADDR_CMD: rd_val = cmd_r & 8'h11;
            `SCR_ADDR_PTR_R: rd_val = ptr_red_r;
            `SCR_ADDR_DAT_R: rd_val = ram_red_r[ptr_red_r];
            `SCR_ADDR_PTR_G: rd_val = ptr_green_r;
            `SCR_ADDR_DAT_G: rd_val = ram_green_r[ptr_green_r];
            `SCR_ADDR_PTR_B: rd_val = ptr_blue_r;
            `SCR_ADDR_DAT_B: rd_val = ram_blue_r[ptr_blue_r];
            `SCR_ADDR_UNLOCK: rd_val = unlock_r;
            default: rd_val = 8'h00;
        endcase
    end

    // Serial frame engine
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bit_cnt_r <= 3'h0;
            hdr_done_r <= 1'b0;
            is_read_r <= 1'b0;
            addr_r <= 7'h00;
            shift_r <= 8'h00;
            byte_cnt_r <= 9'h000;
            out_sh_r <= 8'h00;
            SERIAL_DATA_OUT <= 1'b0;
            SERIAL_DATA_OE <= 1'b0;
        end else if (CE) begin
            if (!frame_act) begin
                bit_cnt_r <= 3'h0;
                hdr_done_r <= 1'b0;
                is_read_r <= 1'b0;
                byte_cnt_r <= 9'h000;
                SERIAL_DATA_OE <= 1'b0;
            end else if (sck_rise) begin
                shift_r <= sh_nxt;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (rd_fire) begin
                    hdr_done_r <= 1'b1;
                    is_read_r <= 1'b1;
                    addr_r <= rd_addr;
                    out_sh_r <= rd_val;
                    SERIAL_DATA_OUT <= rd_val[7];
                    SERIAL_DATA_OE <= acc_rd;
                end else if (byte_end && !hdr_done_r) begin
                    hdr_done_r <= 1'b1;
                    addr_r <= rd_addr;
                end else if (byte_end && is_read_r) begin
                    SERIAL_DATA_OE <= 1'b0;
                end else if (wr_fire) begin
                    byte_cnt_r <= byte_cnt_r + 9'h001;
                    if (!is_data(addr_r))
                        addr_r <= addr_r + 7'h01;
                end
            end else if (sck_fall && SERIAL_DATA_OE) begin
                out_sh_r <= {out_sh_r[6:0], 1'b0};
                SERIAL_DATA_OUT <= out_sh_r[6];
            end
        end
    end

    // Configuration registers; power-down pin returns them to defaults
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_r <= `SCR_RST_CMD;
            dith1_r <= `SCR_RST_DITH1;
            dith2_r <= `SCR_RST_DITH2;
            cfg3_r <= `SCR_RST_CFG3;
            unlock_r <= `SCR_RST_UNLOCK;
            ptr_red_r <= 8'h00;
            ptr_green_r <= 8'h00;
            ptr_blue_r <= 8'h00;
        end else if (CE) begin
            if (pd_low) begin
                cmd_r <= `SCR_RST_CMD;
                dith1_r <= `SCR_RST_DITH1;
                dith2_r <= `SCR_RST_DITH2;
                cfg3_r <= `SCR_RST_CFG3;
                unlock_r <= `SCR_RST_UNLOCK;
                ptr_red_r <= 8'h00;
                ptr_green_r <= 8'h00;
                ptr_blue_r <= 8'h00;
            end else begin
                if (wr_ok) begin
                    case (addr_r)
                        `SCR_ADDR_CMD: cmd_r <= sh_nxt;
                        `SCR_ADDR_PTR_R: ptr_red_r <= sh_nxt;
                        `SCR_ADDR_PTR_G: ptr_green_r <= sh_nxt;
                        `SCR_ADDR_PTR_B: ptr_blue_r <= sh_nxt;
                        `SCR_ADDR_DITH1: dith1_r <= sh_nxt;
                        `SCR_ADDR_DITH2: dith2_r <= sh_nxt;
                        `SCR_ADDR_CFG3: cfg3_r <= sh_nxt;
                        `SCR_ADDR_UNLOCK: unlock_r <= sh_nxt;
                        default: cmd_r <= cmd_r;
                    endcase
                end
                // Pointer steps after every data read or write
                if (ptr_step(`SCR_ADDR_DAT_R, wr_ok, addr_r, rd_ok, rd_addr))
                    ptr_red_r <= ptr_red_r + 8'h01;
                if (ptr_step(`SCR_ADDR_DAT_G, wr_ok, addr_r, rd_ok, rd_addr))
                    ptr_green_r <= ptr_green_r + 8'h01;
                if (ptr_step(`SCR_ADDR_DAT_B, wr_ok, addr_r, rd_ok, rd_addr))
                    ptr_blue_r <= ptr_blue_r + 8'h01;
            end
        end
    end

    // Table memories carry no reset so sleep and power-down keep them
    always @(posedge CLK) begin
        if (CE && wr_ok) begin
            if (addr_r == `SCR_ADDR_DAT_R)
                ram_red_r[ptr_red_r] <= sh_nxt;
            if (addr_r == `SCR_ADDR_DAT_G)
                ram_green_r[ptr_green_r] <= sh_nxt;
            if (addr_r == `SCR_ADDR_DAT_B)
                ram_blue_r[ptr_blue_r] <= sh_nxt;
        end
    end

    // Pixel clock stall detector
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stall_cnt_r <= 12'h000;
            stall_r <= 1'b0;
        end else if (CE) begin
            // Any filtered edge wakes; the count halts at the limit
            if (pck_edge) begin
                stall_cnt_r <= 12'h000;
                stall_r <= 1'b0;
            end else if (stall_cnt_r == STALL_CYCLES[11:0] - 12'h001) begin
                stall_r <= 1'b1;
            end else begin
                stall_cnt_r <= stall_cnt_r + 12'h001;
            end
        end
    end

    // Status, multiplier and table lookup outputs
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LINK_MULT <= `SCR_MULT_18;
            SERIALIZER_RESET <= 1'b1;
            SLEEP <= 1'b1;
            PORT_ENABLE <= 1'b0;
            RED_OUT <= 8'h00;
            GREEN_OUT <= 8'h00;
            BLUE_OUT <= 8'h00;
        end else if (CE) begin
            LINK_MULT <= cfg3_r[`SCR_CFG3_MODE24] ? `SCR_MULT_24 :
                `SCR_MULT_18;
            SLEEP <= pd_low | stall_r;
            SERIALIZER_RESET <= cfg3_r[`SCR_CFG3_SOFT_RST] | pd_low |
                stall_r;
            PORT_ENABLE <= (unlock_r == `SCR_UNLOCK_KEY) & ~pd_low;
            if (cmd_r[`SCR_CMD_LUT_EN]) begin
                RED_OUT <= ram_red_r[RED_IN];
                GREEN_OUT <= ram_green_r[GREEN_IN];
                BLUE_OUT <= ram_blue_r[BLUE_IN];
            end else begin
                RED_OUT <= RED_IN;
                GREEN_OUT <= GREEN_IN;
                BLUE_OUT <= BLUE_IN;
            end
        end
    end

    assign TABLE_ENABLE = cmd_r[`SCR_CMD_LUT_EN];
    assign DITHER_BYPASS = dith1_r[`SCR_DITH_BYPASS];
    assign DITHER_ENABLE_POLARITY_FLIP = dith1_r[`SCR_DITH_DE_FLIP];
    assign DITHER_VSYNC_POLARITY_FLIP = dith1_r[`SCR_DITH_VS_FLIP];
    assign PATTERN_TRANSPOSE_SELECT = dith1_r[`SCR_DITH_TRANSPOSE];
    assign TEMPORAL_DITHER_ON = dith1_r[`SCR_DITH_TEMPORAL];
    assign DITHER_AMPLITUDE_SELECT = dith1_r[`SCR_DITH_AMPL];
    assign DITHER_PARAMETER = dith2_r;
    assign MODE_24 = cfg3_r[`SCR_CFG3_MODE24];
    assign DRIVE_LEVEL = cfg3_r[`SCR_CFG3_DRIVE_HI:`SCR_CFG3_DRIVE_LO];

endmodule // scr_config_regs

//--- scr_config_regs_checker.sv
/* Port checker for scr_config_regs.
   Bound to every scr_config_regs instance; sees only its ports. */
`timescale 1ns/100ps
module scr_config_regs_checker #(
    parameter STALL_CYCLES = 250
) (
    input wire CLK,
    input wire RESET_N,
    input wire SERIAL_SELECT_N,
    input wire POWER_DOWN_N,
    input wire PIXEL_CLK,
    input wire [7:0] RED_IN,
    input wire [7:0] RED_OUT,
    input wire SERIAL_DATA_OE,
    input wire TABLE_ENABLE,
    input wire DITHER_BYPASS,
    input wire [7:0] DITHER_PARAMETER,
    input wire MODE_24,
    input wire [3:0] LINK_MULT,
    input wire SERIALIZER_RESET,
    input wire SLEEP,
    input wire PORT_ENABLE
);
    reg pclk_q_r;
    reg [15:0] still_r;
    // Cycles since the pixel clock pin last moved
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pclk_q_r <= 1'b0;
            still_r <= 16'h0000;
        end else begin
            pclk_q_r <= PIXEL_CLK;
            still_r <= (pclk_q_r != PIXEL_CLK) ? 16'h0000 : still_r + {15'h0000, ~&still_r};
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_mult_track: assert property (1'b1 |=> LINK_MULT == ($past(MODE_24) ? 4'h8 : 4'h6))
        else $error("link multiplier wrong");
    a_pd_port: assert property (!POWER_DOWN_N [*8] |-> !PORT_ENABLE && SLEEP)
        else $error("port open or awake in power-down");
    a_pd_defaults: assert property (!POWER_DOWN_N [*8] |-> !TABLE_ENABLE && DITHER_BYPASS
        && DITHER_PARAMETER == 8'h67 && !MODE_24)
        else $error("registers not at defaults in power-down");
    a_oe_idle: assert property (SERIAL_SELECT_N [*6] |-> !SERIAL_DATA_OE)
        else $error("data output driven while deselected");
    a_stall_sleep: assert property (still_r > STALL_CYCLES + 8 |-> SLEEP && SERIALIZER_RESET)
        else $error("no sleep on stalled pixel clock");
    a_pixel_pass: assert property (!TABLE_ENABLE |=> RED_OUT == $past(RED_IN))
        else $error("pixel not passed through with table off");
    a_cfg_hold: assert property ((SERIAL_SELECT_N && POWER_DOWN_N) [*8] |=>
        $stable(TABLE_ENABLE) && $stable(DITHER_PARAMETER) && $stable(MODE_24))
        else $error("setting changed without a frame");
    a_sleep_rst: assert property (SLEEP [*2] |-> SERIALIZER_RESET)
        else $error("serializer not held in reset while asleep");
endmodule // scr_config_regs_checker

bind scr_config_regs scr_config_regs_checker #(.STALL_CYCLES(STALL_CYCLES)) chk (
    .CLK(CLK), .RESET_N(RESET_N), .SERIAL_SELECT_N(SERIAL_SELECT_N),
    .POWER_DOWN_N(POWER_DOWN_N), .PIXEL_CLK(PIXEL_CLK), .RED_IN(RED_IN), .RED_OUT(RED_OUT),
    .SERIAL_DATA_OE(SERIAL_DATA_OE), .TABLE_ENABLE(TABLE_ENABLE), .DITHER_BYPASS(DITHER_BYPASS),
    .DITHER_PARAMETER(DITHER_PARAMETER), .MODE_24(MODE_24), .LINK_MULT(LINK_MULT),
    .SERIALIZER_RESET(SERIALIZER_RESET), .SLEEP(SLEEP), .PORT_ENABLE(PORT_ENABLE));

//--- scr_host_model.sv
/* Serial host model for the configuration port.
   Bit time 125 ns; serial clock idles low and stands still between frames. */
`timescale 1ns/100ps
module scr_host_model (
    output reg sel_n,
    output reg sclk,
    output reg sdi,
    input wire sdo,
    input wire sdo_oe
);
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end
    // One byte MSB first; a released device line reads as its inverse
    task shift(input [7:0] d, output [7:0] q);
        integer i;
        begin
            q = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                sdi = d[i];
                #62.5 sclk = 1'b1;
                #62.5 q = {q[6:0], sdo_oe ? sdo : ~sdo};
                sclk = 1'b0;
            end
        end
    endtask
    task start(input [7:0] hdr);
        reg [7:0] q;
        begin
            sel_n = 1'b0;
            #62.5 shift(hdr, q);
        end
    endtask
    // Released data line shows the inverse of its last value
    task stop;
        begin
            #62.5 sel_n = 1'b1;
            sdi = ~sdi;
            #100;
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        reg [7:0] q;
        begin
            start({1'b0, a});
            shift(d, q);
            stop;
        end
    endtask
    task rd(input [6:0] a, output [7:0] d);
        reg [7:0] q0;
        reg [7:0] q1;
        begin
            sel_n = 1'b0;
            #62.5 shift({1'b1, a}, q0);
            shift(8'h55, q1);
            d = {q0[0], q1[7:1]};
            stop;
        end
    endtask
endmodule // scr_host_model

//--- tb_scr_config_regs.sv
/* Self-checking testbench for scr_config_regs with the serial host model.
   Short stall count; pixel clock 8 MHz, gated by the bench. */
`timescale 1ns/100ps
`include "scr_regs.vh"
module tb_scr_config_regs;
    reg clk, reset_n, pd_n, pclk, pclk_run;
    reg [7:0] red_in, q;
    wire sel_n, sclk, sdi, sdo, oe, tbl, byp, dep, vsp, tra, tmp, amp, m24, srst, slp, pen;
    wire [7:0] red_out, green_out, blue_out, dpar;
    wire [1:0] drv;
    wire [3:0] mult;
    integer errors, num_checks, i;
    scr_config_regs #(.STALL_CYCLES(40)) uut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1),
        .SERIAL_SELECT_N(sel_n), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(sdi), .POWER_DOWN_N(pd_n),
        .PIXEL_CLK(pclk), .RED_IN(red_in), .GREEN_IN(red_in), .BLUE_IN(red_in),
        .RED_OUT(red_out), .GREEN_OUT(green_out), .BLUE_OUT(blue_out), .SERIAL_DATA_OUT(sdo),
        .SERIAL_DATA_OE(oe), .TABLE_ENABLE(tbl), .DITHER_BYPASS(byp),
        .DITHER_ENABLE_POLARITY_FLIP(dep), .DITHER_VSYNC_POLARITY_FLIP(vsp),
        .PATTERN_TRANSPOSE_SELECT(tra), .TEMPORAL_DITHER_ON(tmp),
        .DITHER_AMPLITUDE_SELECT(amp), .DITHER_PARAMETER(dpar), .MODE_24(m24),
        .DRIVE_LEVEL(drv), .LINK_MULT(mult), .SERIALIZER_RESET(srst), .SLEEP(slp),
        .PORT_ENABLE(pen));
    scr_host_model host (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(oe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        pclk = 1'b0;
        forever #62.5 if (pclk_run) pclk = ~pclk;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task wait_slp(input v);
        begin
            i = 0;
            while (slp !== v && i < 200) begin
                @(negedge clk);
                i = i + 1;
            end
            chk({7'h00, slp}, {7'h00, v});
            if (slp !== v) finish_test;
        end
    endtask
    // Flags packed table, bypass, flips, transpose, temporal, amplitude, mode
    task chk_flags(input [7:0] exp);
        chk({tbl, byp, dep, vsp, tra, tmp, amp, m24}, exp);
    endtask
    task t_defaults;
        begin
            chk_flags(8'h56);
            chk(dpar, 8'h67);
            chk({4'h0, mult}, 8'h06);
            chk({5'h00, drv, pen}, 8'h00);
            $display("test defaults done");
        end
    endtask
    task t_lock;
        begin
            host.wr(`SCR_ADDR_CMD, 8'h01);
            host.wr(`SCR_ADDR_UNLOCK, 8'hFE);
            chk({pen, tbl}, 8'h00);
            // Locked port leaves the data line released
            host.rd(`SCR_ADDR_CMD, q);
            chk(q, 8'hFF);
            host.wr(`SCR_ADDR_UNLOCK, 8'hFF);
            host.wr(`SCR_ADDR_DITH1, 8'h00);
            chk({pen, byp}, 8'h03);
            $display("test lock done");
        end
    endtask
    task t_config;
        begin
            host.wr(`SCR_ADDR_CMD, 8'h10);
            host.wr(`SCR_ADDR_DITH1, 8'h00);
            chk_flags(8'h00);
            host.wr(`SCR_ADDR_DITH1, 8'h76);
            chk_flags(8'h3E);
            host.wr(`SCR_ADDR_CFG3, 8'h11);
            chk({drv, m24, mult}, 8'h38);
            host.rd(`SCR_ADDR_DITH1, q);
            chk(q, 8'h00);
            host.rd(`SCR_ADDR_CMD, q);
            chk(q & 8'h11, 8'h10);
            host.wr(`SCR_ADDR_CFG3, 8'h00);
            chk({drv, m24, mult}, 8'h06);
            $display("test config done");
        end
    endtask
    task t_table;
        begin
            host.wr(`SCR_ADDR_PTR_R, 8'hFE);
            host.start({1'b0, `SCR_ADDR_DAT_R});
            for (i = 0; i < 4; i = i + 1) host.shift(8'hC0 + i[7:0], q);
            host.stop;
            host.rd(`SCR_ADDR_PTR_R, q);
            chk(q, 8'h02);
            host.rd(`SCR_ADDR_PTR_G, q);
            chk(q, 8'h00);
            host.wr(`SCR_ADDR_DAT_G, 8'hA5);
            host.wr(`SCR_ADDR_DAT_B, 8'h5A);
            host.rd(`SCR_ADDR_PTR_B, q);
            chk(q, 8'h01);
            host.wr(`SCR_ADDR_PTR_R, 8'hFF);
            host.rd(`SCR_ADDR_DAT_R, q);
            chk(q, 8'hC1);
            host.rd(`SCR_ADDR_PTR_R, q);
            chk(q, 8'h00);
            host.wr(`SCR_ADDR_CMD, 8'h11);
            @(negedge clk) red_in = 8'h00;
            repeat (2) @(negedge clk);
            chk(red_out, 8'hC2);
            chk(green_out, 8'hA5);
            chk(blue_out, 8'h5A);
            $display("test table done");
        end
    endtask
    task t_stall;
        begin
            pclk_run = 1'b1;
            wait_slp(1'b0);
            chk({7'h00, srst}, 8'h00);
            host.wr(`SCR_ADDR_CFG3, 8'h02);
            chk({7'h00, srst}, 8'h01);
            host.wr(`SCR_ADDR_CFG3, 8'h00);
            pclk_run = 1'b0;
            wait_slp(1'b1);
            chk({tbl, pen}, 8'h03);
            // Keep the pixel clock stopped beyond four periods
            repeat (130) @(negedge clk);
            chk({7'h00, slp}, 8'h01);
            pclk_run = 1'b1;
            wait_slp(1'b0);
            $display("test stall done");
        end
    endtask
    task t_powerdown;
        begin
            @(negedge clk) pd_n = 1'b0;
            wait_slp(1'b1);
            chk({7'h00, pen}, 8'h00);
            @(negedge clk) pd_n = 1'b1;
            wait_slp(1'b0);
            chk_flags(8'h56);
            chk(dpar, 8'h67);
            chk({6'h00, pen, srst}, 8'h00);
            host.wr(`SCR_ADDR_UNLOCK, 8'hFF);
            host.wr(`SCR_ADDR_CMD, 8'h01);
            @(negedge clk) red_in = 8'h01;
            repeat (2) @(negedge clk);
            chk(red_out, 8'hC3);
            $display("test powerdown done");
        end
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        pd_n = 1'b1;
        pclk_run = 1'b0;
        red_in = 8'h00;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        t_defaults;
        t_lock;
        t_config;
        t_table;
        t_stall;
        t_powerdown;
        finish_test;
    end
endmodule // tb_scr_config_regs
